// ---- hw/dual_timer.sv ----
// Purpose: Two timer/counters in 13-bit mode behind an AHB-Lite slave.
// Assumes: Count and gate pins are asynchronous; the CPU clock is clk.
// Notes:   Zero wait states; every access answers OKAY.
//
// How it works
// - Timer function counts once per six clocks.
// - Counter function counts count-pin falling edges.
// - Count pin sampled once per machine cycle.
// - Fall recognition spans two machine cycles.
// - New count visible the following machine cycle.
// - Function select bit picks timer or counter.
// - Two-bit mode field per timer.
// - Mode zero count is thirteen bits.
// - Upper three low-byte bits are ignored.
// - Wrap to zero sets overflow flag.
// - Run bit and gate-or-pin enable counting.
// - Setting run bit keeps count contents.
// - Gate bits at mode bits seven, three.
// - Run bits live in control register.
// - Overflow can toggle the count pin.
// - Toggle output starts high when enabled.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`include "timer_defines.svh"
module dual_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        count_pin_zero_in,
  input  wire logic        count_pin_one_in,
  output logic             count_pin_zero_out,
  output logic             count_pin_zero_oe,
  output logic             count_pin_one_out,
  output logic             count_pin_one_oe,
  input  wire logic        ext_int_zero_n,
  input  wire logic        ext_int_one_n
);

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Pins reach logic only after two flops; the first flop feeds nothing else.
  logic [3:0] pin_meta_r;
  logic [3:0] pin_sync_r;
  logic [3:0] pin_raw;

  assign pin_raw = {ext_int_one_n, ext_int_zero_n, count_pin_one_in, count_pin_zero_in};

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_meta_r <= 4'hF;
      pin_sync_r <= 4'hF;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // Machine-cycle divider
  // --------------------------------------------------------------------------
  logic [`MCYC_CNT_W-1:0] mcyc_r;
  logic                   tick;

  assign tick = (mcyc_r == `MCYC_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      mcyc_r <= '0;
    end else begin
      mcyc_r <= tick ? '0 : mcyc_r + `MCYC_CNT_W'(1);
    end
  end

  // --------------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------------
  logic [7:0]  addr_r;
  logic        wr_pend_r;
  logic        take;
  logic        wr_take;
  logic [7:0]  wbyte;
  logic        wr_mode;
  logic        wr_ctrl;
  logic        wr_low0;
  logic        wr_high0;
  logic        wr_low1;
  logic        wr_high1;
  logic        wr_tog;
  logic [31:0] rd_word;

  assign take    = hsel & hready & htrans[1];
  assign wr_take = take & hwrite;
  assign wbyte   = hwdata[7:0];
  assign wr_mode  = wr_pend_r & (addr_r == `OFS_MODE);
  assign wr_ctrl  = wr_pend_r & (addr_r == `OFS_CTRL);
  assign wr_low0  = wr_pend_r & (addr_r == `OFS_LOW0);
  assign wr_high0 = wr_pend_r & (addr_r == `OFS_HIGH0);
  assign wr_low1  = wr_pend_r & (addr_r == `OFS_LOW1);
  assign wr_high1 = wr_pend_r & (addr_r == `OFS_HIGH1);
  assign wr_tog   = wr_pend_r & (addr_r == `OFS_TOGGLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      addr_r    <= 8'h00;
      wr_pend_r <= 1'b0;
    end else begin
      if (take) begin
        addr_r <= haddr[7:0];
      end
      wr_pend_r <= wr_take;
    end
  end

  // --------------------------------------------------------------------------
  // Mode, control and toggle registers
  // --------------------------------------------------------------------------
  logic [7:0] mode_r;
  logic [7:0] ctrl_r;
  logic [1:0] tog_en_r;
  logic [1:0] tog_lvl_r;
  logic [1:0] ovf_evt;
  logic [1:0] ovf_flag_nxt;
  logic [1:0] run;
  logic [1:0] tog_en_nxt;

  count_ctl_if cc0 ();
  count_ctl_if cc1 ();

  assign ovf_evt = {cc1.overflow, cc0.overflow};
  assign run     = {ctrl_r[`CTRL_RUN1_BIT], ctrl_r[`CTRL_RUN0_BIT]};
  assign tog_en_nxt = wr_tog ? {wbyte[`TOG_EN1_BIT], wbyte[`TOG_EN0_BIT]} : tog_en_r;
  // A new overflow wins over a software clear in the same cycle.
  assign ovf_flag_nxt[0] = ovf_evt[0]
                         | (wr_ctrl ? wbyte[`CTRL_OVF0_BIT] : ctrl_r[`CTRL_OVF0_BIT]);
  assign ovf_flag_nxt[1] = ovf_evt[1]
                         | (wr_ctrl ? wbyte[`CTRL_OVF1_BIT] : ctrl_r[`CTRL_OVF1_BIT]);

  always_ff @(posedge clk) begin
    if (rst) begin
      mode_r <= `MODE_RESET;
    end else if (wr_mode) begin
      mode_r <= wbyte;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_r <= `CTRL_RESET;
    end else begin
      ctrl_r <= {ovf_flag_nxt[1], (wr_ctrl ? wbyte[`CTRL_RUN1_BIT] : run[1]),
                 ovf_flag_nxt[0], (wr_ctrl ? wbyte[`CTRL_RUN0_BIT] : run[0]),
                 (wr_ctrl ? wbyte[3:0] : ctrl_r[3:0])};
    end
  end

  // Enabling the toggle drives one until the first overflow flips it.
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_tog
      always_ff @(posedge clk) begin
        if (rst) begin
          tog_en_r[gi]  <= 1'b0;
          tog_lvl_r[gi] <= 1'b1;
        end else begin
          tog_en_r[gi] <= tog_en_nxt[gi];
          if (tog_en_nxt[gi] & ~tog_en_r[gi]) begin
            tog_lvl_r[gi] <= 1'b1;
          end else if (tog_en_r[gi] & ovf_evt[gi]) begin
            tog_lvl_r[gi] <= ~tog_lvl_r[gi];
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Counters
  // --------------------------------------------------------------------------
  // Gating: run and (gate clear or external interrupt pin high).
  assign cc0.tick      = tick;
  assign cc0.use_pin   = mode_r[`MODE_CT0_BIT];
  assign cc0.pin_sync  = pin_sync_r[0];
  assign cc0.enable    = run[0] & (~mode_r[`MODE_GATE0_BIT] | pin_sync_r[2]);
  assign cc0.load_low  = wr_low0;
  assign cc0.load_high = wr_high0;
  assign cc0.wdata     = wbyte;
  assign cc0.mode      = mode_r[1:0];

  assign cc1.tick      = tick;
  assign cc1.use_pin   = mode_r[`MODE_CT1_BIT];
  assign cc1.pin_sync  = pin_sync_r[1];
  assign cc1.enable    = run[1] & (~mode_r[`MODE_GATE1_BIT] | pin_sync_r[3]);
  assign cc1.load_low  = wr_low1;
  assign cc1.load_high = wr_high1;
  assign cc1.wdata     = wbyte;
  assign cc1.mode      = mode_r[5:4];

  count_unit u_count0 (
    .clk (clk),
    .rst (rst),
    .c   (cc0.cnt)
  );

  count_unit u_count1 (
    .clk (clk),
    .rst (rst),
    .c   (cc1.cnt)
  );

  // --------------------------------------------------------------------------
  // Read data and outputs
  // --------------------------------------------------------------------------
  assign rd_word = (haddr[7:0] == `OFS_MODE)   ? {24'h000000, mode_r} :
                   (haddr[7:0] == `OFS_CTRL)   ? {24'h000000, ctrl_r} :
                   (haddr[7:0] == `OFS_LOW0)   ? {24'h000000, cc0.low} :
                   (haddr[7:0] == `OFS_HIGH0)  ? {24'h000000, cc0.high} :
                   (haddr[7:0] == `OFS_LOW1)   ? {24'h000000, cc1.low} :
                   (haddr[7:0] == `OFS_HIGH1)  ? {24'h000000, cc1.high} :
                   (haddr[7:0] == `OFS_TOGGLE) ? {30'h00000000, tog_en_r} :
                   32'h00000000;

  always_ff @(posedge clk) begin
    if (rst) begin
      hrdata             <= 32'h00000000;
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      count_pin_zero_out <= 1'b1;
      count_pin_zero_oe  <= 1'b0;
      count_pin_one_out  <= 1'b1;
      count_pin_one_oe   <= 1'b0;
    end else begin
      if (take & ~hwrite) begin
        hrdata <= rd_word;
      end
      hreadyout          <= 1'b1;
      hresp              <= 1'b0;
      count_pin_zero_out <= tog_lvl_r[0];
      count_pin_zero_oe  <= tog_en_r[0];
      count_pin_one_out  <= tog_lvl_r[1];
      count_pin_one_oe   <= tog_en_r[1];
    end
  end

endmodule

// ---- hw/timer_defines.svh ----
// Purpose: Offsets, field positions, reset values and timing counts of the timer block.
// Assumes: AHB-Lite register bus, 32-bit data, word-aligned registers.
// Notes:   Definitions only.
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// ----------------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------------
`define OFS_MODE        8'h00
`define OFS_CTRL        8'h04
`define OFS_LOW0        8'h08
`define OFS_HIGH0       8'h0C
`define OFS_LOW1        8'h10
`define OFS_HIGH1       8'h14
`define OFS_TOGGLE      8'h18

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define MODE_GATE1_BIT  7
`define MODE_CT1_BIT    6
`define MODE_GATE0_BIT  3
`define MODE_CT0_BIT    2
`define CTRL_OVF1_BIT   7
`define CTRL_RUN1_BIT   6
`define CTRL_OVF0_BIT   5
`define CTRL_RUN0_BIT   4
`define TOG_EN0_BIT     0
`define TOG_EN1_BIT     1

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define MODE_RESET      8'h00
`define CTRL_RESET      8'h00
`define TOG_RESET       8'h00
`define CPU_CLK_HZ      20000000
`define CLKS_PER_MCYC   6
`define MCYC_NS         (`CLKS_PER_MCYC * 1000000000 / `CPU_CLK_HZ)
`define MCYC_CNT_W      3
`define MCYC_LAST       3'h5

`endif

// ---- hw/timer_pkg.sv ----
// Purpose: Shared types of the timer block.
// Assumes: Nothing beyond the defines header.
// Notes:   Mode codes follow the two-bit mode field.
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_RELOAD,
    MODE_SPLIT
  } timer_mode_type;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WRITE,
    BUS_READ
  } bus_phase_type;

endpackage

// ---- hw/count_ctl_if.sv ----
// Purpose: Carries controls and results between the timer top and one counter.
// Assumes: Single clock domain.
// Notes:   One instance per timer.
`timescale 1ns/10ps
interface count_ctl_if;
  logic       tick;
  logic       use_pin;
  logic       pin_sync;
  logic       enable;
  logic       load_low;
  logic       load_high;
  logic [7:0] wdata;
  logic [1:0] mode;
  logic [7:0] low;
  logic [7:0] high;
  logic       overflow;

  modport ctl (
    output tick, use_pin, pin_sync, enable, load_low, load_high, wdata, mode,
    input  low, high, overflow
  );
  modport cnt (
    input  tick, use_pin, pin_sync, enable, load_low, load_high, wdata, mode,
    output low, high, overflow
  );
endinterface

// ---- hw/count_unit.sv ----
// Purpose: One 13-bit up counter with machine-cycle or falling-edge pin source.
// Assumes: The pin input is already synchronised; tick marks a machine-cycle boundary.
// Notes:   Only the 13-bit mode counts; other modes hold the count.
`timescale 1ns/10ps
module count_unit (
  input  wire logic   clk,
  input  wire logic   rst,
  count_ctl_if.cnt    c
);

  logic [7:0] low_r;
  logic [7:0] high_r;
  logic       sample_r;
  logic       fall_r;
  logic       ovf_r;
  logic       fall_nxt;
  logic       step;
  logic [12:0] count_now;
  logic [12:0] count_inc;
  logic       wrap;

  // --------------------------------------------------------------------------
  // Source selection
  // --------------------------------------------------------------------------
  // A fall seen at one tick is counted at the next tick, so it shows one
  // machine cycle after detection.
  assign fall_nxt  = sample_r & ~c.pin_sync;
  assign step      = c.tick & c.enable & (c.mode == timer_pkg::MODE_13BIT)
                   & (c.use_pin ? fall_r : 1'b1);
  assign count_now = {high_r, low_r[4:0]};
  assign count_inc = count_now + 13'h0001;
  assign wrap      = step & (count_now == 13'h1FFF);

  always_ff @(posedge clk) begin
    if (rst) begin
      sample_r <= 1'b1;
      fall_r   <= 1'b0;
    end else if (c.tick) begin
      sample_r <= c.pin_sync;
      fall_r   <= fall_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // Count registers
  // --------------------------------------------------------------------------
  // Upper three low-byte bits are left untouched by counting.
  always_ff @(posedge clk) begin
    if (rst) begin
      low_r  <= 8'h00;
      high_r <= 8'h00;
    end else begin
      if (c.load_low) begin
        low_r <= c.wdata;
      end else if (step) begin
        low_r <= {low_r[7:5], count_inc[4:0]};
      end
      if (c.load_high) begin
        high_r <= c.wdata;
      end else if (step) begin
        high_r <= count_inc[12:5];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ovf_r <= 1'b0;
    end else begin
      ovf_r <= wrap;
    end
  end

  assign c.low      = low_r;
  assign c.high     = high_r;
  assign c.overflow = ovf_r;

endmodule

// ---- sim/timer_checker.sv ----
// Purpose: Port-level assertions for the dual timer.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Attached to every dual_timer by the bind below.
`timescale 1ns/10ps
module timer_checker (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  input  wire logic        hreadyout,
  input  wire logic        hresp,
  input  wire logic        count_pin_zero_out,
  input  wire logic        count_pin_zero_oe,
  input  wire logic        count_pin_one_out,
  input  wire logic        count_pin_one_oe
);
  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic take_r;
  logic take_w;
  assign take_r = hsel && hready && htrans[1] && !hwrite;
  assign take_w = hsel && hready && htrans[1] && hwrite;

  AST_OKAY: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  AST_UPPER_ZERO: assert property (hrdata[31:8] == 24'h000000)
    else $error("read data upper bits not zero");
  AST_UNMAPPED_ZERO: assert property (take_r && haddr[7:0] > 8'h18 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_TOG0_START: assert property ($rose(count_pin_zero_oe) |-> count_pin_zero_out)
    else $error("toggle output zero not high on enable");
  AST_TOG1_START: assert property ($rose(count_pin_one_oe) |-> count_pin_one_out)
    else $error("toggle output one not high on enable");
  // The enable lands at the end of the data phase and reaches the pin one clock later.
  AST_TOG0_EN: assert property (take_w && haddr[7:0] == 8'h18 |=>
    ##2 (count_pin_zero_oe == $past(hwdata[0], 2))) else $error("toggle enable zero wrong");
  AST_TOG1_EN: assert property (take_w && haddr[7:0] == 8'h18 |=>
    ##2 (count_pin_one_oe == $past(hwdata[1], 2))) else $error("toggle enable one wrong");
  AST_TOG0_SPACING: assert property ($changed(count_pin_zero_out) && count_pin_zero_oe
    && $past(count_pin_zero_oe) |=> $stable(count_pin_zero_out)[*5])
    else $error("toggle zero changed faster than one machine cycle");
endmodule

bind dual_timer timer_checker timer_checker_i (.clk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .count_pin_zero_out, .count_pin_zero_oe,
  .count_pin_one_out, .count_pin_one_oe);

// ---- sim/pin_source.sv ----
// Purpose: External source of count pulses and gate levels.
// Assumes: Changes its outputs just after a rising clock edge.
// Notes:   Idles high on every line.
`timescale 1ns/10ps
module pin_source (
  input  wire logic clk,
  output logic      pin_zero,
  output logic      pin_one,
  output logic      gate_zero_n,
  output logic      gate_one_n
);
  initial begin
    pin_zero = 1'b1;
    pin_one = 1'b1;
    gate_zero_n = 1'b1;
    gate_one_n = 1'b1;
  end
  // Each level is held hold clocks; six is the fastest the device may see.
  task automatic send_falls(input int n, input int hold);
    repeat (n) begin
      @(posedge clk);
      pin_one <= 1'b0;
      repeat (hold) @(posedge clk);
      pin_one <= 1'b1;
      repeat (hold - 1) @(posedge clk);
    end
  endtask
  task automatic set_gate_zero(input logic v);
    @(posedge clk);
    gate_zero_n <= v;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench of the dual timer.
// Assumes: Zero-wait AHB-Lite slave, 50 ns clock.
// Notes:   One task per scenario.
`timescale 1ns/10ps
`include "timer_defines.svh"
module tb_top;
  logic        clk;
  logic        rst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        pz_out;
  logic        pz_oe;
  logic        po_out;
  logic        po_oe;
  logic        src_zero;
  logic        src_one;
  logic        gate_zero_n;
  logic        gate_one_n;
  logic [31:0] rd;
  int          err_count;
  int          check_count;
  // A pin the device drives shows the device's level.
  wire logic   pin_zero = pz_oe ? pz_out : src_zero;
  wire logic   pin_one = po_oe ? po_out : src_one;

  dual_timer dual_timer_i (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .count_pin_zero_in(pin_zero),
    .count_pin_one_in(pin_one), .count_pin_zero_out(pz_out), .count_pin_zero_oe(pz_oe),
    .count_pin_one_out(po_out), .count_pin_one_oe(po_oe), .ext_int_zero_n(gate_zero_n),
    .ext_int_one_n(gate_one_n));
  pin_source pin_source_i (.clk(clk), .pin_zero(src_zero), .pin_one(src_one),
    .gate_zero_n(gate_zero_n), .gate_one_n(gate_one_n));

  // ----------------------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------------------
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h000000, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    check_count++;
    if (((got >= lo) && (got <= hi)) !== 1'b1) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h, range %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    bus(1'b0, a, 8'h00);
    chk(rd, lo, hi);
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic reg_test();
    rdchk(`OFS_MODE, 32'h00, 32'h00);
    bus(1'b1, `OFS_MODE, 8'hCC);
    rdchk(`OFS_MODE, 32'hCC, 32'hCC);
    bus(1'b1, `OFS_CTRL, 8'h0A);
    rdchk(`OFS_CTRL, 32'h0A, 32'h0A);
    rdchk(8'h1C, 32'h00, 32'h00);
    bus(1'b1, `OFS_CTRL, 8'h00);
  endtask
  task automatic timer_test();
    logic [31:0] first;
    bus(1'b1, `OFS_MODE, 8'h08);
    bus(1'b1, `OFS_LOW0, 8'h00);
    bus(1'b1, `OFS_HIGH0, 8'h00);
    pin_source_i.set_gate_zero(1'b0);
    bus(1'b1, `OFS_CTRL, 8'h10);
    repeat (60) @(posedge clk);
    rdchk(`OFS_LOW0, 32'h00, 32'h00);
    pin_source_i.set_gate_zero(1'b1);
    repeat (60) @(posedge clk);
    bus(1'b1, `OFS_CTRL, 8'h00);
    rdchk(`OFS_LOW0, 32'h09, 32'h0C);
    first = rd;
    bus(1'b1, `OFS_CTRL, 8'h10);
    repeat (30) @(posedge clk);
    bus(1'b1, `OFS_CTRL, 8'h00);
    rdchk(`OFS_LOW0, first + 32'h4, first + 32'h7);
  endtask
  task automatic overflow_test();
    bus(1'b1, `OFS_MODE, 8'h00);
    bus(1'b1, `OFS_TOGGLE, 8'h03);
    chk({31'h0, pz_out}, 32'h1, 32'h1);
    bus(1'b1, `OFS_HIGH0, 8'hFF);
    bus(1'b1, `OFS_LOW0, 8'hFF);
    bus(1'b1, `OFS_CTRL, 8'h10);
    repeat (20) @(posedge clk);
    rdchk(`OFS_CTRL, 32'h30, 32'h30);
    chk({31'h0, pz_out}, 32'h0, 32'h0);
    rdchk(`OFS_HIGH0, 32'h00, 32'h00);
    rdchk(`OFS_LOW0, 32'h00, 32'hFF);
    chk(rd & 32'h1F, 32'h01, 32'h07);
    bus(1'b1, `OFS_CTRL, 8'h00);
    rdchk(`OFS_CTRL, 32'h00, 32'h00);
    bus(1'b1, `OFS_TOGGLE, 8'h00);
  endtask
  task automatic counter_test();
    bus(1'b1, `OFS_MODE, 8'h40);
    bus(1'b1, `OFS_LOW1, 8'h00);
    bus(1'b1, `OFS_HIGH1, 8'h00);
    bus(1'b1, `OFS_CTRL, 8'h40);
    pin_source_i.send_falls(3, 12);
    pin_source_i.send_falls(3, 6);
    repeat (24) @(posedge clk);
    rdchk(`OFS_LOW1, 32'h06, 32'h06);
  endtask

  task automatic give_verdict();
    $display("Comparisons: %0d, mismatches: %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    give_verdict();
  end
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    err_count = 0;
    check_count = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    reg_test();
    timer_test();
    overflow_test();
    counter_test();
    give_verdict();
  end
endmodule
